// ==== src/opd_decode_map.svh ====
// Opcode values, field positions and reset values of the opcode decoder
`ifndef OPD_DECODE_MAP_SVH
`define OPD_DECODE_MAP_SVH

// ============================================================
// Field positions inside an opcode byte
`define OPD_X_HI 7
`define OPD_X_LO 6
`define OPD_Y_HI 5
`define OPD_Y_LO 3
`define OPD_Z_HI 2
`define OPD_Z_LO 0

// ============================================================
// Base page opcodes with a decode of their own
`define OPD_OP_NOP 8'h00
`define OPD_OP_HALT 8'h76
`define OPD_OP_COPY_HH 8'h64
`define OPD_OP_PFX_BIT 8'hcb
`define OPD_OP_PFX_IX 8'hdd
`define OPD_OP_PFX_EXT 8'hed
`define OPD_OP_PFX_IY 8'hfd

// ============================================================
// Operand and row codes
`define OPD_R_MEM_HL 3'h6
`define OPD_CB_UNSUP_ROW 3'h6
`define OPD_RST_STEP_LSB 3'h0

// ============================================================
// Reset values of the decoded outputs
`define OPD_RST_FIELD 3'h0
`define OPD_RST_PAIR 2'h0
`define OPD_RST_VEC 8'h00
`define OPD_RST_IMM 2'h0

`endif

// ==== src/opd_pkg.sv ====
// Types shared by the opcode decoder files
package opd_pkg;

    // ============================================================
    // Operation classes handed to the execution units
    typedef enum logic [5:0] {
        C_NOP = 6'b000000, C_HALT = 6'b000001, C_LD_R_R = 6'b000010,
        C_LD_R_N = 6'b000011, C_LD_RP_NN = 6'b000100,
        C_INC_RP = 6'b000101, C_DEC_RP = 6'b000110,
        C_ADD_HL_RP = 6'b000111, C_INC_R = 6'b001000,
        C_DEC_R = 6'b001001, C_LD_IND = 6'b001010,
        C_ALU_R = 6'b001011, C_ALU_N = 6'b001100,
        C_ROT_ACC = 6'b001101, C_ACC_MISC = 6'b001110,
        C_DEC_B_BRANCH = 6'b001111, C_JR = 6'b010000,
        C_JR_CC = 6'b010001, C_JP = 6'b010010, C_JP_CC = 6'b010011,
        C_JP_HL = 6'b010100, C_CALL = 6'b010101,
        C_CALL_CC = 6'b010110, C_RET = 6'b010111,
        C_RET_CC = 6'b011000, C_RESTART = 6'b011001,
        C_POP = 6'b011010, C_PUSH = 6'b011011,
        C_SWAP_ACC_FLAGS = 6'b011100, C_SWAP_BANKS = 6'b011101,
        C_SWAP_DE_HL = 6'b011110, C_SWAP_SP_HL = 6'b011111,
        C_COPY_HL_SP = 6'b100000, C_PORT_OUT = 6'b100001,
        C_PORT_IN = 6'b100010, C_INT_DISABLE = 6'b100011,
        C_INT_ENABLE = 6'b100100, C_PREFIX = 6'b100101,
        C_SHIFT_ROT = 6'b100110, C_BIT_TEST = 6'b100111,
        C_BIT_NOP = 6'b101000, C_BIT_OTHER = 6'b101001,
        C_RESERVED = 6'b101010, C_FOREIGN = 6'b101011
    } opd_class_e;

    // ============================================================
    // Opcode page that the next byte belongs to
    typedef enum logic [1:0] {
        PG_BASE = 2'b00,
        PG_BIT = 2'b01,
        PG_OTHER = 2'b10
    } opd_page_e;

endpackage : opd_pkg

// ==== src/opd_prefix_sense.sv ====
// Recognises the four prefix bytes of the base page
`timescale 1ns/1ps
`default_nettype none
`include "opd_decode_map.svh"

module opd_prefix_sense (
    input wire logic [7:0] op_i, // Opcode byte
    output logic is_bit_o, // Bit-operation page prefix
    output logic is_ix_o, // First index page prefix
    output logic is_ext_o, // Extended page prefix
    output logic is_iy_o // Second index page prefix
);

    // ============================================================
    // Plain compares; the caller decides which page is live
    assign is_bit_o = (op_i == `OPD_OP_PFX_BIT);
    assign is_ix_o = (op_i == `OPD_OP_PFX_IX);
    assign is_ext_o = (op_i == `OPD_OP_PFX_EXT);
    assign is_iy_o = (op_i == `OPD_OP_PFX_IY);

endmodule : opd_prefix_sense
`default_nettype wire

// ==== src/opd_bit_page.sv ====
// Decoder for the rotate, shift and bit-test page
`timescale 1ns/1ps
`default_nettype none
`include "opd_decode_map.svh"

module opd_bit_page (
    input wire logic [7:0] op_i, // Byte after the bit prefix
    output opd_pkg::opd_class_e class_o, // Operation class
    output logic [2:0] sub_o, // Shift kind or bit number
    output logic [2:0] reg_o // Operand register, 6 is memory
);

    logic [1:0] x; // Row group
    logic [2:0] y; // Middle field

    assign x = op_i[`OPD_X_HI:`OPD_X_LO];
    assign y = op_i[`OPD_Y_HI:`OPD_Y_LO];
    assign reg_o = op_i[`OPD_Z_HI:`OPD_Z_LO];
    assign sub_o = y;

    // ============================================================
    // Row group picks the class; clear and set rows are passed on
    always_comb begin
        unique case (x)
            2'b00: begin
                // Row 30h-37h has no shift behind it
                if (y == `OPD_CB_UNSUP_ROW) begin
                    class_o = opd_pkg::C_BIT_NOP;
                end else begin
                    class_o = opd_pkg::C_SHIFT_ROT;
                end
            end
            2'b01: class_o = opd_pkg::C_BIT_TEST;
            2'b10, 2'b11: class_o = opd_pkg::C_BIT_OTHER;
        endcase
    end

endmodule : opd_bit_page
`default_nettype wire

// ==== src/opd_decoder.sv ====
// Opcode decoder for the base page and the bit-operation page
`timescale 1ns/1ps
`default_nettype none
`include "opd_decode_map.svh"

// Behaviour
// - Non-prefix base bytes decode; 00h does nothing
// - CBh selects bit page, DDh defers like EDh
// - EDh and FDh defer to next byte
// - 40h-7Fh copy register except 76h halt, y destination, z source
// - Debug variant reserves 64h
// - 80h-9Fh add, adc, sub, sbc by eights
// - A0h-A7h AND, B0h-B7h OR
// - A8h-AFh XOR, B8h-BFh compare
// - Column 6 of C0h-FFh: immediate ALU
// - Conditional return, jump, call by condition
// - Restart vector is y times eight
// - Pops and pushes of BC, DE, HL, AF
// - F3h/FBh interrupts, E3h swaps HL, stack
// - D3h port write, DBh port read
// - D9h banks, 08h AF, EBh, C9h return
// - Decrement-branch, relative jumps, conditional relatives
// - Pair immediate loads, increments, decrements
// - Add pair into HL, jump HL, SP
// - Accumulator rotates and four flag/adjust ops
// - Bit page rows: rotates and shifts
// - Bit page 30h-37h unsupported
// - Bit page 40h-7Fh: bit tests
module opd_decoder #(
    parameter int OPCODE_W = 8, // Opcode byte width
    parameter bit DEBUG_VARIANT = 1'b0 // Debug build reserves 64h
) (
    input wire logic clk_sys_i, // System clock, 100 MHz
    input wire logic rstn_i, // Asynchronous reset, active low
    input wire logic op_valid_i, // Fetch offers an opcode byte
    input wire logic [OPCODE_W-1:0] op_byte_i, // Opcode byte
    output logic dec_valid_o, // Decoded fields valid, one cycle
    output opd_pkg::opd_class_e op_class_o, // Operation class
    output logic [2:0] sub_op_o, // ALU, rotate or misc kind
    output logic [2:0] dst_sel_o, // Destination register code
    output logic [2:0] src_sel_o, // Source register code
    output logic [1:0] pair_sel_o, // Register pair code
    output logic [2:0] cond_o, // Branch condition code
    output logic [7:0] rst_vec_o, // Restart vector
    output logic [2:0] bit_num_o, // Bit number on bit page
    output logic [1:0] imm_bytes_o, // Operand bytes that follow
    output logic pfx_bit_o, // Bit page prefix seen
    output logic pfx_ix_o, // First index prefix seen
    output logic pfx_ext_o, // Extended prefix seen
    output logic pfx_iy_o // Second index prefix seen
);

    // ============================================================
    // Elaboration check
    if (OPCODE_W != 8) begin : g_bad_width
        $error("opd_decoder serves 8-bit opcodes only");
    end

    // ============================================================
    // Declarations
    opd_pkg::opd_page_e page; // Page of the next byte
    opd_pkg::opd_page_e next_page; // Page after this byte
    opd_pkg::opd_class_e next_class; // Class from the live page
    opd_pkg::opd_class_e base_class; // Base page class
    opd_pkg::opd_class_e bit_class; // Bit page class
    logic [2:0] bit_sub; // Bit page middle field
    logic [2:0] bit_reg; // Bit page operand
    logic [2:0] next_sub; // Sub-operation
    logic [2:0] next_dst; // Destination
    logic [2:0] next_src; // Source
    logic [1:0] next_pair; // Pair
    logic [2:0] next_cond; // Condition
    logic [7:0] next_vec; // Restart vector
    logic [2:0] next_bit; // Bit number
    logic [1:0] next_imm; // Immediate byte count
    logic is_bit; // Prefix compares
    logic is_ix;
    logic is_ext;
    logic is_iy;
    logic in_base; // Byte taken on the base page
    logic [1:0] x; // Opcode fields
    logic [2:0] y;
    logic [2:0] z;
    logic [1:0] p;
    logic q;

    assign x = op_byte_i[`OPD_X_HI:`OPD_X_LO];
    assign y = op_byte_i[`OPD_Y_HI:`OPD_Y_LO];
    assign z = op_byte_i[`OPD_Z_HI:`OPD_Z_LO];
    assign p = y[2:1];
    assign q = y[0];
    assign in_base = op_valid_i && (page == opd_pkg::PG_BASE);

    // ============================================================
    // Leaf decoders
    opd_prefix_sense u_prefix (
        .op_i(op_byte_i),
        .is_bit_o(is_bit),
        .is_ix_o(is_ix),
        .is_ext_o(is_ext),
        .is_iy_o(is_iy)
    );

    opd_bit_page u_bit_page (
        .op_i(op_byte_i),
        .class_o(bit_class),
        .sub_o(bit_sub),
        .reg_o(bit_reg)
    );

    // ============================================================
    // Base page decode; the regular x/y/z fields carry operands,
    // so the misprinted 85h and 8Dh rows fall out as register L
    always_comb begin
        base_class = opd_pkg::C_NOP;
        next_sub = y; // ALU op in rows 80h-BFh
        next_dst = y;
        next_src = z; // Operand field
        next_pair = p;
        next_cond = y; // Eight conditions by y
        next_vec = {2'b00, y, `OPD_RST_STEP_LSB};
        next_imm = 2'd0;
        unique case (x)
            2'b00: begin
                unique case (z)
                    3'd0: begin
                        // Relative branches take one offset byte
                        unique case (y)
                            3'd0: base_class = opd_pkg::C_NOP;
                            3'd1: base_class = opd_pkg::C_SWAP_ACC_FLAGS;
                            3'd2: base_class = opd_pkg::C_DEC_B_BRANCH;
                            3'd3: base_class = opd_pkg::C_JR;
                            default: base_class = opd_pkg::C_JR_CC;
                        endcase
                        next_cond = {1'b0, y[1:0]};
                        next_imm = (y > 3'd1) ? 2'd1 : 2'd0;
                    end
                    3'd1: begin
                        // Pair load or add into HL
                        base_class = q ? opd_pkg::C_ADD_HL_RP
                                       : opd_pkg::C_LD_RP_NN;
                        next_imm = q ? 2'd0 : 2'd2;
                    end
                    3'd2: begin
                        // Indirect accumulator and HL moves
                        base_class = opd_pkg::C_LD_IND;
                        next_imm = p[1] ? 2'd2 : 2'd0;
                    end
                    3'd3: base_class = q ? opd_pkg::C_DEC_RP
                                         : opd_pkg::C_INC_RP;
                    3'd4: base_class = opd_pkg::C_INC_R;
                    3'd5: base_class = opd_pkg::C_DEC_R;
                    3'd6: begin
                        base_class = opd_pkg::C_LD_R_N;
                        next_imm = 2'd1;
                    end
                    3'd7: begin
                        // Rotates in y 0-3, adjust and flags in 4-7
                        base_class = y[2] ? opd_pkg::C_ACC_MISC
                                          : opd_pkg::C_ROT_ACC;
                    end
                endcase
            end
            2'b01: begin
                // Register copies, with two carve-outs
                if (op_byte_i == `OPD_OP_HALT) begin
                    base_class = opd_pkg::C_HALT;
                end else if (DEBUG_VARIANT &&
                             op_byte_i == `OPD_OP_COPY_HH) begin
                    base_class = opd_pkg::C_RESERVED;
                end else begin
                    base_class = opd_pkg::C_LD_R_R;
                end
            end
            2'b10: base_class = opd_pkg::C_ALU_R;
            2'b11: begin
                unique case (z)
                    3'd0: base_class = opd_pkg::C_RET_CC;
                    3'd1: begin
                        // Pair code 3 means AF here, not SP
                        if (!q) begin
                            base_class = opd_pkg::C_POP;
                        end else begin
                            unique case (p)
                                2'd0: base_class = opd_pkg::C_RET;
                                2'd1: base_class = opd_pkg::C_SWAP_BANKS;
                                2'd2: base_class = opd_pkg::C_JP_HL;
                                2'd3: base_class = opd_pkg::C_COPY_HL_SP;
                            endcase
                        end
                    end
                    3'd2: begin
                        base_class = opd_pkg::C_JP_CC;
                        next_imm = 2'd2;
                    end
                    3'd3: begin
                        unique case (y)
                            3'd0: begin
                                base_class = opd_pkg::C_JP;
                                next_imm = 2'd2;
                            end
                            3'd1: base_class = opd_pkg::C_PREFIX;
                            3'd2: begin
                                base_class = opd_pkg::C_PORT_OUT;
                                next_imm = 2'd1;
                            end
                            3'd3: begin
                                base_class = opd_pkg::C_PORT_IN;
                                next_imm = 2'd1;
                            end
                            3'd4: base_class = opd_pkg::C_SWAP_SP_HL;
                            3'd5: base_class = opd_pkg::C_SWAP_DE_HL;
                            3'd6: base_class = opd_pkg::C_INT_DISABLE;
                            3'd7: base_class = opd_pkg::C_INT_ENABLE;
                        endcase
                    end
                    3'd4: begin
                        base_class = opd_pkg::C_CALL_CC;
                        next_imm = 2'd2;
                    end
                    3'd5: begin
                        if (!q) begin
                            base_class = opd_pkg::C_PUSH;
                        end else if (p == 2'd0) begin
                            base_class = opd_pkg::C_CALL;
                            next_imm = 2'd2;
                        end else begin
                            base_class = opd_pkg::C_PREFIX;
                        end
                    end
                    3'd6: begin
                        base_class = opd_pkg::C_ALU_N;
                        next_imm = 2'd1;
                    end
                    3'd7: base_class = opd_pkg::C_RESTART;
                endcase
            end
        endcase
    end

    // ============================================================
    // Pick the live page; bytes after index or extended prefixes
    // belong to decoders elsewhere and are only flagged foreign
    always_comb begin
        unique case (page)
            opd_pkg::PG_BIT: next_class = bit_class;
            opd_pkg::PG_OTHER: next_class = opd_pkg::C_FOREIGN;
            default: next_class = base_class;
        endcase
    end

    always_comb begin
        next_page = page;
        if (op_valid_i) begin
            if (page != opd_pkg::PG_BASE) begin
                next_page = opd_pkg::PG_BASE;
            end else if (is_bit) begin
                next_page = opd_pkg::PG_BIT;
            end else if (is_ix || is_ext || is_iy) begin
                next_page = opd_pkg::PG_OTHER;
            end
        end
    end

    // ============================================================
    // Page register; an illegal code falls back to the base page
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            page <= opd_pkg::PG_BASE;
        end else begin
            page <= next_page;
        end
    end

    // ============================================================
    // Valid strobe, one cycle after the byte is offered
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dec_valid_o <= 1'b0;
        end else begin
            dec_valid_o <= op_valid_i;
        end
    end

    // ============================================================
    // Decoded fields; held between bytes so units can sample late
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_class_o <= opd_pkg::C_NOP;
            sub_op_o <= `OPD_RST_FIELD;
            dst_sel_o <= `OPD_RST_FIELD;
            src_sel_o <= `OPD_RST_FIELD;
            pair_sel_o <= `OPD_RST_PAIR;
            cond_o <= `OPD_RST_FIELD;
            rst_vec_o <= `OPD_RST_VEC;
            bit_num_o <= `OPD_RST_FIELD;
            imm_bytes_o <= `OPD_RST_IMM;
        end else if (op_valid_i) begin
            op_class_o <= next_class;
            bit_num_o <= bit_sub;
            if (page == opd_pkg::PG_BIT) begin
                // Shift or test acts in place on one operand
                sub_op_o <= bit_sub;
                dst_sel_o <= bit_reg;
                src_sel_o <= bit_reg;
                imm_bytes_o <= 2'd0;
            end else begin
                sub_op_o <= next_sub;
                dst_sel_o <= next_dst;
                src_sel_o <= next_src;
                imm_bytes_o <= (page == opd_pkg::PG_BASE) ? next_imm
                                                          : 2'd0;
            end
            pair_sel_o <= next_pair;
            cond_o <= next_cond;
            rst_vec_o <= next_vec;
        end
    end

    // ============================================================
    // Prefix flags; a pulse with the class of the prefix byte
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pfx_bit_o <= 1'b0;
            pfx_ix_o <= 1'b0;
            pfx_ext_o <= 1'b0;
            pfx_iy_o <= 1'b0;
        end else begin
            pfx_bit_o <= in_base && is_bit;
            pfx_ix_o <= in_base && is_ix;
            pfx_ext_o <= in_base && is_ext;
            pfx_iy_o <= in_base && is_iy;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb_dec @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_base(logic [7:0] b);
        in_base && op_byte_i == b;
    endsequence

    sequence s_bit_byte;
        op_valid_i && page == opd_pkg::PG_BIT;
    endsequence

    a_nop_decode: assert property (
        s_base(`OPD_OP_NOP) |=> dec_valid_o &&
            op_class_o == opd_pkg::C_NOP && imm_bytes_o == 2'd0)
        else $error("00h did not decode as no-operation");

    a_bit_prefix_page: assert property (
        s_base(`OPD_OP_PFX_BIT) ##1 op_valid_i |=> pfx_bit_o == 1'b0 &&
            (op_class_o == opd_pkg::C_SHIFT_ROT ||
             op_class_o == opd_pkg::C_BIT_TEST ||
             op_class_o == opd_pkg::C_BIT_NOP ||
             op_class_o == opd_pkg::C_BIT_OTHER))
        else $error("byte after bit prefix left the bit page");

    a_ext_prefix_defer: assert property (
        s_base(`OPD_OP_PFX_EXT) ##1 op_valid_i |->
            pfx_ext_o && op_class_o == opd_pkg::C_PREFIX
            ##1 op_class_o == opd_pkg::C_FOREIGN)
        else $error("extended prefix did not defer the next byte");

    a_reg_copy_fields: assert property (
        in_base && x == 2'b01 && op_byte_i != `OPD_OP_HALT &&
        !(DEBUG_VARIANT && op_byte_i == `OPD_OP_COPY_HH) |=>
            op_class_o == opd_pkg::C_LD_R_R &&
            dst_sel_o == $past(y) && src_sel_o == $past(z))
        else $error("register copy fields wrong");

    a_halt_decode: assert property (
        s_base(`OPD_OP_HALT) |=> op_class_o == opd_pkg::C_HALT)
        else $error("76h did not decode as halt");

    a_alu_reg_op: assert property (
        in_base && x == 2'b10 |=> op_class_o == opd_pkg::C_ALU_R &&
            sub_op_o == $past(y) && src_sel_o == $past(z))
        else $error("register ALU row decoded wrong");

    a_imm_alu_op: assert property (
        in_base && x == 2'b11 && z == 3'd6 |=>
            op_class_o == opd_pkg::C_ALU_N && imm_bytes_o == 2'd1 &&
            sub_op_o == $past(y))
        else $error("immediate ALU row decoded wrong");

    a_restart_vector: assert property (
        in_base && x == 2'b11 && z == 3'd7 |=>
            op_class_o == opd_pkg::C_RESTART &&
            rst_vec_o == {2'b00, $past(y), 3'b000})
        else $error("restart vector is not y times eight");

    a_bit_unsup_nop: assert property (
        s_bit_byte and op_byte_i[7:3] == 5'b00110 |=>
            op_class_o == opd_pkg::C_BIT_NOP && imm_bytes_o == 2'd0)
        else $error("unsupported bit row not a no-operation");

    a_bit_test_fields: assert property (
        s_bit_byte and x == 2'b01 |=> op_class_o == opd_pkg::C_BIT_TEST &&
            bit_num_o == $past(y) && src_sel_o == $past(z))
        else $error("bit test fields wrong");

endmodule : opd_decoder
`default_nettype wire

// ==== verification/opd_fetch_model.sv ====
// Fetch unit model that offers opcode bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module opd_fetch_model (
    input wire logic clk_i, // System clock
    output logic valid_o, // Byte offered this cycle
    output logic [7:0] byte_o // Opcode byte
);
    initial begin
        valid_o = 1'b0;
        byte_o = 8'h00;
    end
    // Offer one byte for one edge; the idle bus then carries the inverse
    // so a stale byte can never pass for a fresh one
    task send(input logic [7:0] b);
        @(negedge clk_i);
        valid_o = 1'b1;
        byte_o = b;
        @(negedge clk_i);
        valid_o = 1'b0;
        byte_o = ~b;
    endtask : send
    // Offer two bytes on two edges in a row, with no idle slot
    task send_pair(input logic [7:0] a, input logic [7:0] b);
        @(negedge clk_i);
        valid_o = 1'b1;
        byte_o = a;
        @(negedge clk_i);
        byte_o = b;
        @(negedge clk_i);
        valid_o = 1'b0;
        byte_o = ~b;
    endtask : send_pair
endmodule : opd_fetch_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_i, rstn_i, op_valid_i, dec_valid_o;
    logic [7:0] op_byte_i, rst_vec_o;
    opd_pkg::opd_class_e op_class_o;
    logic [2:0] sub_op_o, dst_sel_o, src_sel_o, cond_o, bit_num_o;
    logic [1:0] pair_sel_o, imm_bytes_o;
    logic pfx_bit_o, pfx_ix_o, pfx_ext_o, pfx_iy_o;
    int n_mismatch = 0;
    int total_checks = 0;
    // Debug build, so the reserved copy can be seen
    opd_decoder #(.OPCODE_W(8), .DEBUG_VARIANT(1'b1)) uut (
        .clk_sys_i, .rstn_i, .op_valid_i, .op_byte_i, .dec_valid_o,
        .op_class_o, .sub_op_o, .dst_sel_o, .src_sel_o, .pair_sel_o,
        .cond_o, .rst_vec_o, .bit_num_o, .imm_bytes_o, .pfx_bit_o,
        .pfx_ix_o, .pfx_ext_o, .pfx_iy_o
    );
    opd_fetch_model fetch (.clk_i(clk_sys_i), .valid_o(op_valid_i),
        .byte_o(op_byte_i));
    // ============================================================
    // Checking helpers
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Fields are checked half a cycle after the taking edge
    task do_op(input logic [7:0] b, input logic [5:0] c);
        fetch.send(b);
        chk({7'h0, dec_valid_o}, 8'h01);
        chk({2'h0, op_class_o}, {2'h0, c});
    endtask : do_op
    // ============================================================
    // Scenarios
    task t_plain;
        do_op(8'h00, opd_pkg::C_NOP);
        do_op(8'h76, opd_pkg::C_HALT);
        do_op(8'h64, opd_pkg::C_RESERVED);
        do_op(8'h7d, opd_pkg::C_LD_R_R);
        chk({2'h0, dst_sel_o, src_sel_o}, 8'h3d);
    endtask : t_plain
    task t_alu;
        for (int y = 0; y < 8; y++) begin
            do_op(8'h85 + 8'(y * 8), opd_pkg::C_ALU_R);
            chk({2'h0, sub_op_o, src_sel_o}, 8'(y * 8 + 5));
        end
    endtask : t_alu
    // Prefix and its follower back to back, as the fetch unit may
    task t_burst;
        fetch.send_pair(8'hcb, 8'h46);
        chk({2'h0, op_class_o}, {2'h0, opd_pkg::C_BIT_TEST});
        chk({1'h0, pfx_bit_o, bit_num_o, src_sel_o}, 8'h06);
        fetch.send_pair(8'hed, 8'h00);
        chk({2'h0, op_class_o}, {2'h0, opd_pkg::C_FOREIGN});
        chk({7'h0, pfx_ext_o}, 8'h00);
    endtask : t_burst
    // Every row of the top quarter: conditions, immediates, restarts
    task t_rows;
        for (int y = 0; y < 8; y++) begin
            do_op(8'hc0 + 8'(y * 8), opd_pkg::C_RET_CC);
            chk({5'h0, cond_o}, 8'(y));
            do_op(8'hc2 + 8'(y * 8), opd_pkg::C_JP_CC);
            do_op(8'hc4 + 8'(y * 8), opd_pkg::C_CALL_CC);
            do_op(8'hc6 + 8'(y * 8), opd_pkg::C_ALU_N);
            chk({3'h0, sub_op_o, imm_bytes_o}, 8'(y * 4 + 1));
            do_op(8'hc7 + 8'(y * 8), opd_pkg::C_RESTART);
            chk(rst_vec_o, 8'(y * 8));
        end
    endtask : t_rows
    task t_pfx;
        logic [7:0] pb[3] = '{8'hdd, 8'hed, 8'hfd};
        do_op(8'hcb, opd_pkg::C_PREFIX);
        do_op(8'h5e, opd_pkg::C_BIT_TEST);
        chk({2'h0, bit_num_o, src_sel_o}, 8'h1e);
        do_op(8'hcb, opd_pkg::C_PREFIX);
        do_op(8'h33, opd_pkg::C_BIT_NOP);
        do_op(8'hcb, opd_pkg::C_PREFIX);
        do_op(8'h3a, opd_pkg::C_SHIFT_ROT);
        chk({5'h0, sub_op_o}, 8'h07);
        foreach (pb[i]) begin
            do_op(pb[i], opd_pkg::C_PREFIX);
            chk({4'h0, pfx_bit_o, pfx_ix_o, pfx_ext_o, pfx_iy_o},
                8'h04 >> i);
            do_op(8'h00, opd_pkg::C_FOREIGN);
        end
        do_op(8'h00, opd_pkg::C_NOP);
    endtask : t_pfx
    task t_misc;
        logic [13:0] tb[19] = '{{8'hf3, opd_pkg::C_INT_DISABLE},
            {8'hfb, opd_pkg::C_INT_ENABLE}, {8'he3, opd_pkg::C_SWAP_SP_HL},
            {8'hd3, opd_pkg::C_PORT_OUT}, {8'hdb, opd_pkg::C_PORT_IN},
            {8'hd9, opd_pkg::C_SWAP_BANKS}, {8'heb, opd_pkg::C_SWAP_DE_HL},
            {8'h08, opd_pkg::C_SWAP_ACC_FLAGS}, {8'hc9, opd_pkg::C_RET},
            {8'h10, opd_pkg::C_DEC_B_BRANCH}, {8'h28, opd_pkg::C_JR_CC},
            {8'h31, opd_pkg::C_LD_RP_NN}, {8'h0b, opd_pkg::C_DEC_RP},
            {8'h39, opd_pkg::C_ADD_HL_RP}, {8'he9, opd_pkg::C_JP_HL},
            {8'hf9, opd_pkg::C_COPY_HL_SP}, {8'h1f, opd_pkg::C_ROT_ACC},
            {8'h3f, opd_pkg::C_ACC_MISC}, {8'hf5, opd_pkg::C_PUSH}};
        foreach (tb[i]) begin
            do_op(tb[i][13:6], tb[i][5:0]);
        end
        chk({6'h0, pair_sel_o}, 8'h03);
    endtask : t_misc
    // ============================================================
    // Clock, reset, sequence and verdict
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        rstn_i = 1'b0;
        repeat (16) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        t_plain;
        t_alu;
        t_rows;
        t_pfx;
        t_burst;
        t_misc;
        results;
    end
    // About 200 byte slots are needed; this leaves ample margin
    initial begin
        #20us;
        n_mismatch++;
        results;
    end
endmodule : testbench
`default_nettype wire
